/* rtl/pbm_pkg.sv */
// Functional notes
// - While autoneg is enabled (bit 12), the manual duplex (bit 8) and manual speed (bit 13) bits are ignored.
// - While autoneg is disabled, port speed and duplex come from the manual speed and duplex bits.
// - Reset values of autoneg enable and manual duplex come from the captured autoneg strap select field.
// - Writing power down (bit 11) to one powers the port down; writing zero returns it to normal.
// - Isolate (bit 10) disconnects the port from the MII while register access keeps working.
// - Writing one to restart (bit 9) starts autoneg over from its beginning.
// - With autoneg disabled, a write of one to restart has no effect.
// - Restart reads as one from the write until autoneg has been initiated, then clears itself; the control logic also clears it on a write of zero to bit 9.
// - Software writing zero to restart does not disturb an autoneg process already running.
// - With autoneg disabled, manual duplex one selects full duplex and zero selects half duplex.
// - With collision test (bit 7) set, COL rises within 512 bit times after TXEN rises.
// - In collision test mode, COL falls within 4 bit times after TXEN falls.
// - Bits 6 to 0 are read-only reserved and read as zero.
// - Power down, isolate, restart and collision test reset to zero.
// - With autoneg disabled, manual speed one selects 100 Mb/s and zero selects 10 Mb/s.
package pbm_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [11:0] PBM_ADDR_CONFIG = 12'h04c;
   localparam logic [11:0] PBM_ADDR_CONTROL = 12'h080;
   localparam logic [11:0] PBM_ADDR_PORT_STATE = 12'h0a0;
   localparam int PBM_ADDR_W = 12;

   // ---------------------------------------------------------------
   // Control register fields
   // ---------------------------------------------------------------
   localparam int PBM_BIT_SPEED = 13;
   localparam int PBM_BIT_AN_EN = 12;
   localparam int PBM_BIT_PWR_DOWN = 11;
   localparam int PBM_BIT_ISOLATE = 10;
   localparam int PBM_BIT_AN_RESTART = 9;
   localparam int PBM_BIT_DUPLEX = 8;
   localparam int PBM_BIT_COL_TEST = 7;
   localparam logic PBM_RST_PWR_DOWN = 1'b0;
   localparam logic PBM_RST_ISOLATE = 1'b0;
   localparam logic PBM_RST_AN_RESTART = 1'b0;
   localparam logic PBM_RST_COL_TEST = 1'b0;

   // ---------------------------------------------------------------
   // Strap field inside the config register
   // ---------------------------------------------------------------
   localparam int PBM_STRAP_W = 3;
   localparam int PBM_STRAP_AN = 2;
   localparam int PBM_STRAP_SPEED = 1;
   localparam int PBM_STRAP_DUPLEX = 0;
   localparam logic [PBM_STRAP_W-1:0] PBM_RST_STRAP = 3'h0;
   // Settle count that ends SETTLE; LOAD follows on the fourth edge after reset release
   localparam logic [1:0] PBM_STRAP_SETTLE = 2'h3;

   // ---------------------------------------------------------------
   // Port state register fields
   // ---------------------------------------------------------------
   localparam int PBM_PS_SPEED = 0;
   localparam int PBM_PS_DUPLEX = 1;
   localparam int PBM_PS_TXEN = 2;
   localparam int PBM_PS_COL = 3;
   localparam int PBM_PS_AN_BUSY = 4;

   // ---------------------------------------------------------------
   // Collision test timing
   // ---------------------------------------------------------------
   localparam int PBM_CLK_PERIOD_PS = 8000;
   localparam int PBM_BIT_TIME_PS = 10000;
   localparam int PBM_COL_ON_BIT_TIMES = 512;
   localparam int PBM_COL_OFF_BIT_TIMES = 4;
   localparam int PBM_COL_ON_CYCLES = (PBM_COL_ON_BIT_TIMES * PBM_BIT_TIME_PS) / PBM_CLK_PERIOD_PS;
   localparam int PBM_COL_OFF_CYCLES = (PBM_COL_OFF_BIT_TIMES * PBM_BIT_TIME_PS) / PBM_CLK_PERIOD_PS;

   typedef enum logic [1:0] {
      PBM_ST_SETTLE = 2'b00,
      PBM_ST_LOAD = 2'b01,
      PBM_ST_RUN = 2'b11
   } pbm_state_e;

   typedef struct packed {
      logic autoneg_en;
      logic power_down;
      logic isolate;
      logic speed_100;
      logic full_duplex;
   } pbm_port_mode_s;

endpackage : pbm_pkg

/* rtl/pbm_col_test.sv */
`timescale 1ns/10ps
`default_nettype none

module pbm_col_test
   import pbm_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic enable,
   input wire logic tx_en_pin,
   output logic tx_en_seen,
   output logic col
);

   logic tx_sync1;
   logic tx_sync2;
   logic next_col;

   // ---------------------------------------------------------------
   // Transmit enable synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tx_sync1 <= 1'b0;
         tx_sync2 <= 1'b0;
      end else begin
         tx_sync1 <= tx_en_pin;
         tx_sync2 <= tx_sync1;
      end
   end

   // Three edges from pin to COL, well inside both windows
   always_comb begin
      next_col = enable & tx_sync2;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         col <= 1'b0;
      end else begin
         col <= next_col;
      end
   end

   assign tx_en_seen = tx_sync2;

endmodule // pbm_col_test

`default_nettype wire

/* rtl/pbm_basic_mode_control.sv */
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module pbm_basic_mode_control
   import pbm_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PBM_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Strap pins, sampled once after reset
   input wire logic [PBM_STRAP_W-1:0] autoneg_strap_select,
   // Autoneg engine
   input wire logic autoneg_started,
   input wire logic autoneg_busy,
   input wire logic an_speed_100,
   input wire logic an_full_duplex,
   output logic autoneg_restart,
   // Port mode to the physical layer
   output pbm_port_mode_s port_mode,
   // MII side
   input wire logic mii_tx_en,
   output logic mii_col,
   output logic mii_col_oe
);

   pbm_state_e state;
   pbm_state_e next_state;
   logic [1:0] settle_cnt;
   logic [1:0] next_settle_cnt;
   logic run_d;
   logic next_run_d;

   logic [PBM_STRAP_W-1:0] strap_sync1;
   logic [PBM_STRAP_W-1:0] strap_sync2;
   logic [PBM_STRAP_W-1:0] strap;
   logic [PBM_STRAP_W-1:0] next_strap;

   logic an_en;
   logic pwr_down;
   logic isolate;
   logic an_restart;
   logic duplex;
   logic speed;
   logic col_test;
   logic next_an_en;
   logic next_pwr_down;
   logic next_isolate;
   logic next_an_restart;
   logic next_duplex;
   logic next_speed;
   logic next_col_test;
   logic next_restart_pulse;
   logic restart_pulse;

   logic access;
   logic wr_ctrl;
   logic hit;
   logic [31:0] next_prdata;
   logic [15:0] ctrl_view;
   logic [7:0] port_state_view;
   pbm_port_mode_s next_port_mode;

   logic col_raw;
   logic tx_en_seen;

   // ---------------------------------------------------------------
   // Strap synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         strap_sync1 <= PBM_RST_STRAP;
         strap_sync2 <= PBM_RST_STRAP;
      end else begin
         strap_sync1 <= autoneg_strap_select;
         strap_sync2 <= strap_sync1;
      end
   end

   // ---------------------------------------------------------------
   // Start-up sequence
   // ---------------------------------------------------------------
   // The strap is a pin, so it cannot be loaded under the async reset;
   // the bus is held off until the strapped defaults are in place.
   always_comb begin
      next_state = state;
      next_settle_cnt = settle_cnt;
      next_strap = strap;
      // One cycle of RUN lets read data pick up the strapped defaults first
      next_run_d = (state == PBM_ST_RUN);
      case (state)
         PBM_ST_SETTLE: begin
            next_settle_cnt = settle_cnt + 2'h1;
            if (settle_cnt == PBM_STRAP_SETTLE) begin
               next_state = PBM_ST_LOAD;
            end
         end
         PBM_ST_LOAD: begin
            next_strap = strap_sync2;
            next_state = PBM_ST_RUN;
         end
         PBM_ST_RUN: begin
            next_state = PBM_ST_RUN;
         end
         default: begin
            next_state = PBM_ST_SETTLE;
            next_settle_cnt = 2'h0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state <= PBM_ST_SETTLE;
         settle_cnt <= 2'h0;
         strap <= PBM_RST_STRAP;
         run_d <= 1'b0;
      end else begin
         run_d <= next_run_d;
         state <= next_state;
         settle_cnt <= next_settle_cnt;
         strap <= next_strap;
      end
   end

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   assign pready = run_d;
   assign access = psel & penable & pready;
   assign hit = (paddr == PBM_ADDR_CONTROL) | (paddr == PBM_ADDR_CONFIG) | (paddr == PBM_ADDR_PORT_STATE);
   assign pslverr = access & ~hit;
   // Config and port state are read-only; writes there are dropped
   assign wr_ctrl = access & pwrite & (paddr == PBM_ADDR_CONTROL);

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   always_comb begin
      next_an_en = an_en;
      next_pwr_down = pwr_down;
      next_isolate = isolate;
      next_an_restart = an_restart;
      next_duplex = duplex;
      next_speed = speed;
      next_col_test = col_test;
      next_restart_pulse = 1'b0;
      if (state == PBM_ST_LOAD) begin
         next_an_en = strap_sync2[PBM_STRAP_AN];
         next_duplex = strap_sync2[PBM_STRAP_DUPLEX];
         next_speed = strap_sync2[PBM_STRAP_SPEED];
      end
      if (an_restart & autoneg_started) begin
         next_an_restart = 1'b0;
      end
      if (wr_ctrl) begin
         if (pstrb[1]) begin
            next_speed = pwdata[PBM_BIT_SPEED];
            next_an_en = pwdata[PBM_BIT_AN_EN];
            next_pwr_down = pwdata[PBM_BIT_PWR_DOWN];
            next_isolate = pwdata[PBM_BIT_ISOLATE];
            next_duplex = pwdata[PBM_BIT_DUPLEX];
            // Restart acts on the enable value already in force
            if (pwdata[PBM_BIT_AN_RESTART] & an_en) begin
               next_an_restart = 1'b1;
               next_restart_pulse = 1'b1;
            end else if (!pwdata[PBM_BIT_AN_RESTART]) begin
               // Only the flag is dropped, the engine is not told
               next_an_restart = 1'b0;
            end else begin
               next_an_restart = an_restart;
            end
         end
         if (pstrb[0]) begin
            next_col_test = pwdata[PBM_BIT_COL_TEST];
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         an_en <= 1'b0;
         pwr_down <= PBM_RST_PWR_DOWN;
         isolate <= PBM_RST_ISOLATE;
         an_restart <= PBM_RST_AN_RESTART;
         duplex <= 1'b0;
         speed <= 1'b0;
         col_test <= PBM_RST_COL_TEST;
         restart_pulse <= 1'b0;
      end else begin
         an_en <= next_an_en;
         pwr_down <= next_pwr_down;
         isolate <= next_isolate;
         an_restart <= next_an_restart;
         duplex <= next_duplex;
         speed <= next_speed;
         col_test <= next_col_test;
         restart_pulse <= next_restart_pulse;
      end
   end

   assign autoneg_restart = restart_pulse;

   // ---------------------------------------------------------------
   // Resolved port mode
   // ---------------------------------------------------------------
   always_comb begin
      next_port_mode.autoneg_en = an_en;
      next_port_mode.power_down = pwr_down;
      next_port_mode.isolate = isolate;
      if (an_en) begin
         // Manual bits have no say while negotiating
         next_port_mode.speed_100 = an_speed_100;
         next_port_mode.full_duplex = an_full_duplex;
      end else begin
         next_port_mode.speed_100 = speed;
         next_port_mode.full_duplex = duplex;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         port_mode <= '0;
      end else begin
         port_mode <= next_port_mode;
      end
   end

   // ---------------------------------------------------------------
   // Collision test
   // ---------------------------------------------------------------
   pbm_col_test u_col_test (
      .clock(clock),
      .arst_n(arst_n),
      .enable(col_test),
      .tx_en_pin(mii_tx_en),
      .tx_en_seen(tx_en_seen),
      .col(col_raw)
   );

   // Isolation only releases the MII pins; register access stays alive
   assign mii_col = col_raw;
   assign mii_col_oe = ~isolate;

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   always_comb begin
      ctrl_view = 16'h0000;
      ctrl_view[PBM_BIT_SPEED] = speed;
      ctrl_view[PBM_BIT_AN_EN] = an_en;
      ctrl_view[PBM_BIT_PWR_DOWN] = pwr_down;
      ctrl_view[PBM_BIT_ISOLATE] = isolate;
      ctrl_view[PBM_BIT_AN_RESTART] = an_restart;
      ctrl_view[PBM_BIT_DUPLEX] = duplex;
      ctrl_view[PBM_BIT_COL_TEST] = col_test;
      port_state_view = 8'h00;
      port_state_view[PBM_PS_SPEED] = port_mode.speed_100;
      port_state_view[PBM_PS_DUPLEX] = port_mode.full_duplex;
      port_state_view[PBM_PS_TXEN] = tx_en_seen;
      port_state_view[PBM_PS_COL] = col_raw;
      port_state_view[PBM_PS_AN_BUSY] = autoneg_busy;
      next_prdata = prdata;
      // Refreshed through setup and wait cycles so a read held off at start-up sees loaded values
      if (psel & ~pwrite & ~(penable & pready)) begin
         case (paddr)
            PBM_ADDR_CONTROL: next_prdata = {16'h0000, ctrl_view};
            PBM_ADDR_CONFIG: next_prdata = {29'h0, strap};
            PBM_ADDR_PORT_STATE: next_prdata = {24'h0, port_state_view};
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= next_prdata;
      end
   end

endmodule // pbm_basic_mode_control

`default_nettype wire

/* verification/pbm_basic_mode_control_properties.sv */
`timescale 1ns/10ps
`default_nettype none

module pbm_basic_mode_control_properties
   import pbm_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PBM_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic an_speed_100,
   input wire logic an_full_duplex,
   input wire logic autoneg_restart,
   input wire pbm_port_mode_s port_mode,
   input wire logic mii_tx_en,
   input wire logic mii_col,
   input wire logic mii_col_oe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   logic wr_ctrl;
   // Setup cycle guarantees port_mode still shows the enable from before the write
   assign wr_ctrl = psel && penable && pready && pwrite && paddr == PBM_ADDR_CONTROL && pstrb[1];

   property p_restart_pulse;
      wr_ctrl && pwdata[PBM_BIT_AN_RESTART] && port_mode.autoneg_en |=> autoneg_restart;
   endproperty
   a_restart_pulse: assert property (p_restart_pulse) else $error("restart write gave no pulse");
   property p_restart_cause;
      autoneg_restart |-> $past(wr_ctrl && pwdata[PBM_BIT_AN_RESTART] && port_mode.autoneg_en);
   endproperty
   a_restart_cause: assert property (p_restart_cause) else $error("restart pulse without cause");
   property p_write_mode;
      wr_ctrl |-> ##2 (port_mode.power_down == $past(pwdata[11], 2) && port_mode.isolate == $past(pwdata[10], 2));
   endproperty
   a_write_mode: assert property (p_write_mode) else $error("power down or isolate not applied");
   property p_manual_mode;
      wr_ctrl && !pwdata[12] |-> ##2 (port_mode.speed_100 == $past(pwdata[13], 2)
         && port_mode.full_duplex == $past(pwdata[8], 2));
   endproperty
   a_manual_mode: assert property (p_manual_mode) else $error("manual speed or duplex not applied");
   property p_an_mode;
      port_mode.autoneg_en |-> port_mode.speed_100 == $past(an_speed_100) && port_mode.full_duplex == $past(an_full_duplex);
   endproperty
   a_an_mode: assert property (p_an_mode) else $error("negotiated mode not used");
   property p_isolate_oe;
      1'b1 |=> port_mode.isolate == !$past(mii_col_oe);
   endproperty
   a_isolate_oe: assert property (p_isolate_oe) else $error("collision driver not released");
   property p_col_cause;
      $rose(mii_col) |-> $past(mii_tx_en, 3);
   endproperty
   a_col_cause: assert property (p_col_cause) else $error("collision without transmit");
   property p_col_off;
      !mii_tx_en [*8] |-> !mii_col;
   endproperty
   a_col_off: assert property (p_col_off) else $error("collision held after transmit end");
endmodule // pbm_basic_mode_control_properties

bind pbm_basic_mode_control pbm_basic_mode_control_properties pbm_basic_mode_control_properties_i (.clock, .arst_n,
   .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .an_speed_100, .an_full_duplex, .autoneg_restart,
   .port_mode, .mii_tx_en, .mii_col, .mii_col_oe);

`default_nettype wire

/* verification/pbm_autoneg_model.sv */
`timescale 1ns/10ps
`default_nettype none

module pbm_autoneg_model
   import pbm_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic autoneg_restart,
   input wire logic [7:0] start_delay,
   input wire logic result_speed,
   input wire logic result_duplex,
   output logic autoneg_started,
   output logic autoneg_busy,
   output logic an_speed_100,
   output logic an_full_duplex
);
   logic [7:0] count;
   // The result only changes once a negotiation finishes, as a real link partner would
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         count <= 8'h00;
         autoneg_started <= 1'b0;
         autoneg_busy <= 1'b0;
         an_speed_100 <= 1'b0;
         an_full_duplex <= 1'b0;
      end else begin
         autoneg_started <= 1'b0;
         if (autoneg_restart) begin
            count <= start_delay;
            autoneg_busy <= 1'b1;
         end else if (count == 8'h01) begin
            count <= 8'h00;
            autoneg_started <= 1'b1;
            autoneg_busy <= 1'b0;
            an_speed_100 <= result_speed;
            an_full_duplex <= result_duplex;
         end else if (count != 8'h00) begin
            count <= count - 8'h01;
         end
      end
   end
endmodule // pbm_autoneg_model

`default_nettype wire

/* verification/pbm_basic_mode_control_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module pbm_basic_mode_control_bench
   import pbm_pkg::*;
;
   logic clock = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mii_tx_en = 1'b0;
   logic res_speed = 1'b0, res_duplex = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [7:0] delay = 8'h01;
   logic pready, pslverr, autoneg_started, autoneg_busy, an_speed_100, an_full_duplex;
   logic autoneg_restart, mii_col, mii_col_oe;
   pbm_port_mode_s port_mode;
   int errors = 0, samples_checked = 0, cycles = 0, pulses = 0, n, p;

   pbm_basic_mode_control pbm_basic_mode_control_i (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb(4'hf), .prdata, .pready, .pslverr, .autoneg_strap_select(3'h5), .autoneg_started, .autoneg_busy,
      .an_speed_100, .an_full_duplex, .autoneg_restart, .port_mode, .mii_tx_en, .mii_col, .mii_col_oe);
   pbm_autoneg_model pbm_autoneg_model_i (.clock, .arst_n, .autoneg_restart, .start_delay(delay),
      .result_speed(res_speed), .result_duplex(res_duplex), .autoneg_started, .autoneg_busy, .an_speed_100,
      .an_full_duplex);

   always #4 clock = ~clock;
   // A stuck handshake anywhere ends here instead of hanging the run
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (autoneg_restart === 1'b1) pulses <= pulses + 1;
      if (cycles == 5000) begin
         errors++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // Look mid-cycle so the answer is judged before the edge that takes it
      @(negedge clock);
      while (pready !== 1'b1) begin
         @(posedge clock);
         @(negedge clock);
      end
      q = prdata;
      err = pslverr;
      @(posedge clock);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic t_reset();
      apb(1'b0, PBM_ADDR_CONTROL, 32'h0);
      check(q, 32'h0000_1100);
      check({27'h0, port_mode}, 32'h10);
      apb(1'b1, PBM_ADDR_CONTROL, 32'hffff_d07f);
      apb(1'b0, PBM_ADDR_CONTROL, 32'h0);
      check(q, 32'h0000_1000);
      apb(1'b0, 12'h0f0, 32'h0);
      check({err, q[30:0]}, 32'h8000_0000);
      $display("reset and reserved test done");
   endtask

   task automatic t_restart();
      delay <= 8'd40;
      p = pulses;
      apb(1'b1, PBM_ADDR_CONTROL, 32'h0000_3300);
      apb(1'b0, PBM_ADDR_CONTROL, 32'h0);
      check(q, 32'h0000_3300);
      apb(1'b1, PBM_ADDR_CONTROL, 32'h0000_3100);
      n = 0;
      while (autoneg_started !== 1'b1 && n < 100) begin
         @(posedge clock);
         n++;
      end
      check({31'h0, autoneg_started}, 32'h1);
      check(32'(pulses - p), 32'h1);
      delay <= 8'd3;
      apb(1'b1, PBM_ADDR_CONTROL, 32'h0000_3300);
      repeat (8) @(posedge clock);
      apb(1'b0, PBM_ADDR_CONTROL, 32'h0);
      check(q, 32'h0000_3100);
      check({27'h0, port_mode}, 32'h10);
      $display("restart test done");
   endtask

   task automatic t_manual();
      p = pulses;
      apb(1'b1, PBM_ADDR_CONTROL, 32'h0);
      apb(1'b1, PBM_ADDR_CONTROL, 32'h0200);
      repeat (3) @(posedge clock);
      check(32'(pulses - p), 32'h0);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, PBM_ADDR_CONTROL, {18'h0, i[1], 4'h0, i[0], 8'h00});
         repeat (3) @(posedge clock);
         check({27'h0, port_mode}, {30'h0, i[1:0]});
      end
      $display("manual mode test done");
   endtask

   task automatic t_power_isolate();
      apb(1'b1, PBM_ADDR_CONTROL, 32'h0c00);
      repeat (3) @(posedge clock);
      check({26'h0, mii_col_oe, port_mode}, 32'h0c);
      apb(1'b0, PBM_ADDR_CONTROL, 32'h0);
      check(q, 32'h0c00);
      apb(1'b1, PBM_ADDR_CONTROL, 32'h0);
      repeat (3) @(posedge clock);
      check({26'h0, mii_col_oe, port_mode}, 32'h20);
      $display("power down and isolate test done");
   endtask

   task automatic t_col();
      mii_tx_en <= 1'b1;
      repeat (10) @(posedge clock);
      check({31'h0, mii_col}, 32'h0);
      mii_tx_en <= 1'b0;
      apb(1'b1, PBM_ADDR_CONTROL, 32'h0080);
      mii_tx_en <= 1'b1;
      n = 0;
      while (mii_col !== 1'b1 && n < PBM_COL_ON_CYCLES) begin
         @(posedge clock);
         n++;
      end
      check({31'h0, mii_col}, 32'h1);
      mii_tx_en <= 1'b0;
      n = 0;
      while (mii_col !== 1'b0 && n < PBM_COL_OFF_CYCLES) begin
         @(posedge clock);
         n++;
      end
      check({31'h0, mii_col}, 32'h0);
      $display("collision test done");
   endtask

   initial begin
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      t_reset();
      t_restart();
      t_manual();
      t_power_isolate();
      t_col();
      final_report();
   end
endmodule // pbm_basic_mode_control_bench

`default_nettype wire
